/* timer_pkg.sv */
package timer_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int COUNT_W    = 16;
    localparam int TRIG_N     = 16;
    localparam int TRIG_SEL_W = 4;
    localparam int ADDR_W     = 8;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] STATUS_CONTROL_OFFSET       = 8'h00;
    localparam logic [7:0] COUNTER_OFFSET              = 8'h04;
    localparam logic [7:0] MODULO_OFFSET               = 8'h08;
    localparam logic [7:0] TIMER_CONFIGURATION_OFFSET  = 8'h0C;
    localparam logic [7:0] STATE_OFFSET                = 8'h10;

    // ---------------------------------------------------------------
    // status_control fields
    // ---------------------------------------------------------------
    localparam int CLOCK_MODE_LSB    = 0;
    localparam int COUNT_DOWN_BIT    = 5;
    localparam int OVERFLOW_FLAG_BIT = 8;

    // ---------------------------------------------------------------
    // timer_configuration fields
    // ---------------------------------------------------------------
    localparam int TRIGGER_SELECT_LSB    = 24;
    localparam int RELOAD_ON_TRIGGER_BIT = 18;
    localparam int STOP_ON_OVERFLOW_BIT  = 17;
    localparam int START_ON_TRIGGER_BIT  = 16;
    localparam int DEBUG_BEHAVIOUR_LSB   = 6;
    localparam int DOZE_PAUSE_ENABLE_BIT = 5;

    // writable bits of timer_configuration; all others read zero
    localparam logic [31:0] CONFIGURATION_MASK = 32'h0F07_00E0;
    localparam logic [31:0] CONFIGURATION_RESET = 32'h0000_0000;
    localparam logic [31:0] STATUS_CONTROL_MASK = 32'h0000_0023;
    localparam logic [31:0] STATUS_CONTROL_RESET = 32'h0000_0000;
    localparam logic [15:0] MODULO_RESET = 16'hFFFF;

    // ---------------------------------------------------------------
    // encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] CLOCK_MODE_OFF     = 2'b00;
    localparam logic [1:0] CLOCK_MODE_EVERY   = 2'b01;
    localparam logic [1:0] CLOCK_MODE_HALF    = 2'b10;
    localparam logic [1:0] DEBUG_CONTINUE     = 2'b11;

    typedef enum logic [1:0] {
        COUNTER_IDLE    = 2'b00,
        COUNTER_WAITING = 2'b01,
        COUNTER_RUNNING = 2'b10,
        COUNTER_HALTED  = 2'b11
    } counter_state_type;

endpackage : timer_pkg

/* trigger_if.sv */
`timescale 1ns/1ps
interface trigger_if;
    logic [3:0] select;
    logic       rise;

    modport unit (input select, output rise);
    modport core (output select, input rise);
endinterface : trigger_if

/* trigger_edge_unit.sv */
`timescale 1ns/1ps
module trigger_edge_unit (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic [timer_pkg::TRIG_N-1:0] trig_i,
    trigger_if.unit                        trig
);

    // ---------------------------------------------------------------
    // two-stage synchroniser, selection and rising edge
    // ---------------------------------------------------------------
    logic [timer_pkg::TRIG_N-1:0] sync_first;
    logic [timer_pkg::TRIG_N-1:0] sync_second;
    logic                         last_level;
    logic [timer_pkg::TRIG_N-1:0] next_sync_first;
    logic [timer_pkg::TRIG_N-1:0] next_sync_second;
    logic                         next_last_level;
    logic                         level;

    always_comb begin
        next_sync_first  = trig_i;
        next_sync_second = sync_first;
        level            = sync_second[trig.select];
        next_last_level  = level;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_first  <= '0;
            sync_second <= '0;
            last_level  <= 1'b0;
        end else begin
            sync_first  <= next_sync_first;
            sync_second <= next_sync_second;
            last_level  <= next_last_level;
        end
    end

    // one-cycle pulse on a low-to-high change of the selected input
    assign trig.rise = level & ~last_level;

endmodule : trigger_edge_unit

/* timer_trigger_core.sv */
// Contract
// - trigger_select bits 27:24 pick the input driving start and reload.
// - configuration bits 23:19 are read-only and read as zero.
// - reload_on_trigger set: trigger rise zeroes counter and resets PWM outputs while counter is enabled.
// - while paused by debug or doze, trigger input is ignored.
// - stop_on_overflow set: counter stops after passing modulo, flag set.
// - reloads to zero, by software or trigger, never cause the halt.
// - halted counter resumes only on re-enable or trigger with start set.
// - stop_on_overflow clear: counter keeps counting past overflow.
// - start_on_trigger set: enabled counter waits for first trigger rise.
// - start_on_trigger set: halted counter restarts on trigger rise.
// - after reset counter_clock_mode is zero, counter disabled.
// - debug pause selected: no counting, triggers ignored in debug mode.
// - doze_pause_enable set: no counting, triggers ignored in doze mode.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module timer_trigger_core (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // classic wishbone slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [timer_pkg::ADDR_W-1:0]  adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [31:0]                   dat_i,
    output logic      [31:0]                   dat_o,
    output logic                               ack_o,
    // trigger sources and chip mode inputs
    input  wire logic [timer_pkg::TRIG_N-1:0]  trig_i,
    input  wire logic                          debug_mode_i,
    input  wire logic                          doze_mode_i,
    // timer outputs
    output logic      [timer_pkg::COUNT_W-1:0] counter_o,
    output logic                               overflow_flag_o,
    output logic                               pwm_default_o,
    output logic                               running_o
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_value,
        input logic [31:0] new_value,
        input logic [3:0]  lanes,
        input logic [31:0] mask
    );
        logic [31:0] result;
        result = old_value;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                result[i*8 +: 8] = new_value[i*8 +: 8];
            end
        end
        return result & mask;
    endfunction : merge_bytes

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [31:0]                     status_control;
    logic [31:0]                     timer_configuration;
    logic [timer_pkg::COUNT_W-1:0]   modulo_value;
    logic [timer_pkg::COUNT_W-1:0]   count;
    logic                            overflow_flag;
    logic                            pwm_default;
    logic                            half_tick;
    timer_pkg::counter_state_type    state;
    logic                            ack;
    logic [31:0]                     read_data;
    logic                            debug_first;
    logic                            debug_second;
    logic                            doze_first;
    logic                            doze_second;

    logic [31:0]                     next_status_control;
    logic [31:0]                     next_timer_configuration;
    logic [timer_pkg::COUNT_W-1:0]   next_modulo_value;
    logic [timer_pkg::COUNT_W-1:0]   next_count;
    logic                            next_overflow_flag;
    logic                            next_pwm_default;
    logic                            next_half_tick;
    timer_pkg::counter_state_type    next_state;
    logic                            next_ack;
    logic [31:0]                     next_read_data;
    logic [31:0]                     modulo_merged;

    // ---------------------------------------------------------------
    // decoded fields
    // ---------------------------------------------------------------
    logic [1:0] counter_clock_mode;
    logic       count_down;
    logic       reload_on_trigger;
    logic       stop_on_overflow;
    logic       start_on_trigger;
    logic [1:0] debug_behaviour;
    logic       doze_pause_enable;
    logic       enabled;
    logic       paused;
    logic       tick;
    logic       trig_rise;
    logic       bus_write;
    logic       at_limit;

    trigger_if trig_bus ();

    assign counter_clock_mode = status_control[timer_pkg::CLOCK_MODE_LSB +: 2];
    assign count_down         = status_control[timer_pkg::COUNT_DOWN_BIT];
    assign reload_on_trigger  =
        timer_configuration[timer_pkg::RELOAD_ON_TRIGGER_BIT];
    assign stop_on_overflow   =
        timer_configuration[timer_pkg::STOP_ON_OVERFLOW_BIT];
    assign start_on_trigger   =
        timer_configuration[timer_pkg::START_ON_TRIGGER_BIT];
    assign debug_behaviour    =
        timer_configuration[timer_pkg::DEBUG_BEHAVIOUR_LSB +: 2];
    assign doze_pause_enable  =
        timer_configuration[timer_pkg::DOZE_PAUSE_ENABLE_BIT];
    assign trig_bus.select    =
        timer_configuration[timer_pkg::TRIGGER_SELECT_LSB +:
                            timer_pkg::TRIG_SEL_W];

    assign enabled = (counter_clock_mode != timer_pkg::CLOCK_MODE_OFF);

    // pause in debug unless continue is chosen, pause in doze if enabled
    assign paused = (debug_second &&
                     (debug_behaviour != timer_pkg::DEBUG_CONTINUE))
                    || (doze_second && doze_pause_enable);

    // triggers ignored while paused
    assign trig_rise = trig_bus.rise & ~paused;

    assign tick = enabled && !paused &&
                  ((counter_clock_mode == timer_pkg::CLOCK_MODE_EVERY) ||
                   half_tick);

    assign bus_write = cyc_i & stb_i & we_i & ack;
    assign at_limit  = count_down ? (count == '0) : (count == modulo_value);
    assign modulo_merged = merge_bytes({16'h0000, modulo_value}, dat_i,
                                       sel_i, 32'h0000_FFFF);

    // ---------------------------------------------------------------
    // trigger edge unit
    // ---------------------------------------------------------------
    trigger_edge_unit edge_unit (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .trig_i (trig_i),
        .trig   (trig_bus.unit)
    );

    // ---------------------------------------------------------------
    // bus slave: one wait cycle, ack for every address
    // ---------------------------------------------------------------
    always_comb begin
        next_ack       = cyc_i & stb_i & ~ack;
        next_read_data = 32'h0000_0000;
        if (adr_i == timer_pkg::STATUS_CONTROL_OFFSET) begin
            next_read_data = status_control;
            next_read_data[timer_pkg::OVERFLOW_FLAG_BIT] = overflow_flag;
        end else if (adr_i == timer_pkg::COUNTER_OFFSET) begin
            next_read_data[timer_pkg::COUNT_W-1:0] = count;
        end else if (adr_i == timer_pkg::MODULO_OFFSET) begin
            next_read_data[timer_pkg::COUNT_W-1:0] = modulo_value;
        end else if (adr_i == timer_pkg::TIMER_CONFIGURATION_OFFSET) begin
            // reserved bits 23:19 and others masked to zero
            next_read_data = timer_configuration &
                             timer_pkg::CONFIGURATION_MASK;
        end else if (adr_i == timer_pkg::STATE_OFFSET) begin
            next_read_data[1:0] = state;
            next_read_data[2]   = paused;
        end
    end

    // ---------------------------------------------------------------
    // registers, counter and start/stop control
    // ---------------------------------------------------------------
    always_comb begin
        next_status_control      = status_control;
        next_timer_configuration = timer_configuration;
        next_modulo_value        = modulo_value;
        next_count               = count;
        next_overflow_flag       = overflow_flag;
        next_pwm_default         = 1'b0;
        next_half_tick           = 1'b0;
        next_state               = state;

        if (counter_clock_mode == timer_pkg::CLOCK_MODE_HALF) begin
            next_half_tick = ~half_tick;
        end

        // software writes; the flag clear is write-one
        if (bus_write) begin
            if (adr_i == timer_pkg::STATUS_CONTROL_OFFSET) begin
                next_status_control = merge_bytes(status_control, dat_i,
                    sel_i, timer_pkg::STATUS_CONTROL_MASK);
                if (sel_i[1] && dat_i[timer_pkg::OVERFLOW_FLAG_BIT]) begin
                    next_overflow_flag = 1'b0;
                end
            end else if (adr_i == timer_pkg::COUNTER_OFFSET) begin
                // a write reloads zero unless a tick in the running state overrides it; does not halt
                next_count = '0;
            end else if (adr_i == timer_pkg::MODULO_OFFSET) begin
                next_modulo_value = modulo_merged[timer_pkg::COUNT_W-1:0];
            end else if (adr_i == timer_pkg::TIMER_CONFIGURATION_OFFSET) begin
                next_timer_configuration = merge_bytes(timer_configuration,
                    dat_i, sel_i, timer_pkg::CONFIGURATION_MASK);
            end
        end

        case (state)
            timer_pkg::COUNTER_IDLE: begin
                if (enabled) begin
                    if (start_on_trigger) begin
                        next_state = timer_pkg::COUNTER_WAITING;
                    end else begin
                        next_state = timer_pkg::COUNTER_RUNNING;
                    end
                end
            end
            timer_pkg::COUNTER_WAITING: begin
                if (trig_rise) begin
                    next_state = timer_pkg::COUNTER_RUNNING;
                end
            end
            timer_pkg::COUNTER_RUNNING: begin
                if (tick) begin
                    if (at_limit) begin
                        next_count = count_down ? modulo_value : '0;
                        next_overflow_flag = 1'b1;
                        if (stop_on_overflow &&
                            !(reload_on_trigger && trig_rise)) begin
                            next_state = timer_pkg::COUNTER_HALTED;
                        end
                    end else if (count_down) begin
                        next_count = count - 1'b1;
                    end else begin
                        next_count = count + 1'b1;
                    end
                end
            end
            timer_pkg::COUNTER_HALTED: begin
                if (trig_rise && start_on_trigger) begin
                    next_state = timer_pkg::COUNTER_RUNNING;
                end
            end
            default: begin
                next_state = timer_pkg::COUNTER_IDLE;
            end
        endcase

        // trigger reload wins over counting in the same cycle
        if (enabled && reload_on_trigger && trig_rise) begin
            next_count       = '0;
            next_pwm_default = 1'b1;
        end

        // disabling returns to idle; re-enable restarts a halted counter
        if (!enabled) begin
            next_state = timer_pkg::COUNTER_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_control      <= timer_pkg::STATUS_CONTROL_RESET;
            timer_configuration <= timer_pkg::CONFIGURATION_RESET;
            modulo_value        <= timer_pkg::MODULO_RESET;
            count               <= '0;
            overflow_flag       <= 1'b0;
            pwm_default         <= 1'b0;
            half_tick           <= 1'b0;
            state               <= timer_pkg::COUNTER_IDLE;
            ack                 <= 1'b0;
            read_data           <= 32'h0000_0000;
            debug_first         <= 1'b0;
            debug_second        <= 1'b0;
            doze_first          <= 1'b0;
            doze_second         <= 1'b0;
        end else begin
            status_control      <= next_status_control;
            timer_configuration <= next_timer_configuration;
            modulo_value        <= next_modulo_value;
            count               <= next_count;
            overflow_flag       <= next_overflow_flag;
            pwm_default         <= next_pwm_default;
            half_tick           <= next_half_tick;
            state               <= next_state;
            ack                 <= next_ack;
            read_data           <= next_read_data;
            debug_first         <= debug_mode_i;
            debug_second        <= debug_first;
            doze_first          <= doze_mode_i;
            doze_second         <= doze_first;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign ack_o           = ack;
    assign dat_o           = read_data;
    assign counter_o       = count;
    assign overflow_flag_o = overflow_flag;
    assign pwm_default_o   = pwm_default;
    assign running_o       = (state == timer_pkg::COUNTER_RUNNING);

endmodule : timer_trigger_core

/* timer_trigger_core_properties.sv */
`timescale 1ns/1ps
module timer_trigger_core_checker (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [timer_pkg::ADDR_W-1:0]  adr_i,
    input  wire logic [31:0]                   dat_o,
    input  wire logic                          ack_o,
    input  wire logic [timer_pkg::COUNT_W-1:0] counter_o,
    input  wire logic                          overflow_flag_o,
    input  wire logic                          pwm_default_o,
    input  wire logic                          running_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ack_answer;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("bus request not answered next cycle");
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_conf_reserved;
        ack_o && !we_i && adr_i == timer_pkg::TIMER_CONFIGURATION_OFFSET
            |-> dat_o[23:19] == 5'h00;
    endproperty
    a_conf_reserved: assert property (p_conf_reserved)
        else $error("reserved configuration bits read nonzero");
    property p_reset_state;
        $fell(rst_i) |-> counter_o == 16'h0000 && !running_o
            && !overflow_flag_o;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("counter not idle after reset");
    property p_reload_zero;
        pwm_default_o |-> counter_o == 16'h0000;
    endproperty
    a_reload_zero: assert property (p_reload_zero)
        else $error("reload did not zero the counter");
    property p_pwm_pulse;
        pwm_default_o |=> !pwm_default_o;
    endproperty
    a_pwm_pulse: assert property (p_pwm_pulse)
        else $error("reload pulse longer than one cycle");
    property p_hold_stopped;
        !$past(running_o) && !$past(ack_o) && !pwm_default_o
            |-> $stable(counter_o);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped)
        else $error("counter moved while not running");
    property p_flag_sticky;
        overflow_flag_o && !ack_o |=> overflow_flag_o;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("overflow flag cleared without a write");
    property p_flag_cause;
        $rose(overflow_flag_o) |-> $past(running_o);
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("overflow flag set while not counting");
    property p_reload_no_halt;
        pwm_default_o && $past(running_o) && !$past(ack_o) |-> running_o;
    endproperty
    a_reload_no_halt: assert property (p_reload_no_halt)
        else $error("reload halted the counter");
endmodule : timer_trigger_core_checker

bind timer_trigger_core timer_trigger_core_checker
    timer_trigger_core_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .counter_o(counter_o), .overflow_flag_o(overflow_flag_o),
    .pwm_default_o(pwm_default_o), .running_o(running_o));

/* trigger_source_model.sv */
`timescale 1ns/1ps
module trigger_source_model (
    input  wire logic                         clk_i,
    input  wire logic                         fire_i,
    input  wire logic [3:0]                   index_i,
    output logic      [timer_pkg::TRIG_N-1:0] trig_o
);
    logic [2:0] hold = 3'h0;
    initial trig_o = 16'h0000;
    // held high long enough for the two-stage synchroniser, then low
    always @(posedge clk_i) begin
        if (fire_i) begin
            trig_o <= 16'h0001 << index_i;
            hold   <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
            if (hold == 3'h1)
                trig_o <= 16'h0000;
        end
    end
endmodule : trigger_source_model

/* timer_trigger_start_reload_stop_test.sv */
`timescale 1ns/1ps
module timer_trigger_start_reload_stop_test;
    typedef struct {
        logic [7:0]  adr;
        logic [31:0] wr;
        logic [31:0] exp;
    } row_type;
    row_type rows [5] = '{
        '{8'h0C, 32'hFFFF_FFFF, 32'h0F07_00E0},
        '{8'h0C, 32'h00F8_0000, 32'h0000_0000},
        '{8'h08, 32'hABCD_1234, 32'h0000_1234},
        '{8'h20, 32'h5555_AAAA, 32'h0000_0000},
        '{8'h0C, 32'h0A05_0040, 32'h0A05_0040}};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic        debug_mode_i = 1'b0;
    logic        doze_mode_i  = 1'b0;
    logic        fire  = 1'b0;
    logic [3:0]  index = 4'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [15:0] trig;
    logic [15:0] counter_o;
    logic        overflow_flag_o;
    logic        pwm_default_o;
    logic        running_o;
    int          mismatches = 0;
    int          cmp_count  = 0;
    int          cycles     = 0;
    int          pwm_seen   = 0;

    always #50 clk_i = ~clk_i;

    timer_trigger_core timer_trigger_core_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .trig_i(trig),
        .debug_mode_i(debug_mode_i), .doze_mode_i(doze_mode_i),
        .counter_o(counter_o), .overflow_flag_o(overflow_flag_o),
        .pwm_default_o(pwm_default_o), .running_o(running_o));
    trigger_source_model trigger_source_model_inst (
        .clk_i(clk_i), .fire_i(fire), .index_i(index), .trig_o(trig));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic final_report;
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, exp);
    endtask : rd
    task automatic fire_trig(input logic [3:0] i);
        @(posedge clk_i);
        fire  <= 1'b1;
        index <= i;
        @(posedge clk_i);
        fire  <= 1'b0;
    endtask : fire_trig

    always @(posedge clk_i) begin
        if (pwm_default_o === 1'b1)
            pwm_seen <= pwm_seen + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] c;
        int          n;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00, 32'h0000_0000);
        rd(8'h0C, 32'h0000_0000);
        rd(8'h08, 32'h0000_FFFF);
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].wr);
            rd(rows[i].adr, rows[i].exp);
        end
        // start on trigger, halt on overflow at modulo 4
        wr(8'h08, 32'h0000_0004);
        wr(8'h0C, 32'h0203_0000);
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_0001);
        repeat (10) @(posedge clk_i);
        check(32'(counter_o), 32'h0000_0000);
        fire_trig(4'h2);
        repeat (12) if (running_o !== 1'b1) @(posedge clk_i);
        check(32'(running_o), 32'h0000_0001);
        repeat (20) if (overflow_flag_o !== 1'b1) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        check(32'(overflow_flag_o), 32'h0000_0001);
        check(32'(running_o), 32'h0000_0000);
        check(32'(counter_o), 32'h0000_0000);
        rd(8'h10, 32'h0000_0003);
        fire_trig(4'h2);
        repeat (12) if (running_o !== 1'b1) @(posedge clk_i);
        check(32'(running_o), 32'h0000_0001);
        // no halt without stop on overflow
        wr(8'h00, 32'h0000_0100);
        rd(8'h00, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0000);
        wr(8'h08, 32'h0000_0003);
        wr(8'h00, 32'h0000_0021);
        repeat (20) @(posedge clk_i);
        check(32'(running_o), 32'h0000_0001);
        check(32'(overflow_flag_o), 32'h0000_0001);
        // doze, then debug, pause the counter and mask triggers
        for (int m = 0; m < 2; m++) begin
            wr(8'h00, 32'h0000_0000);
            wr(8'h0C, 32'h0204_0020);
            wr(8'h08, 32'h0000_FFFF);
            wr(8'h00, 32'h0000_0002);
            doze_mode_i  <= (m == 0);
            debug_mode_i <= (m == 1);
            repeat (4) @(posedge clk_i);
            c = counter_o;
            n = pwm_seen;
            fire_trig(4'h2);
            repeat (8) @(posedge clk_i);
            check(32'(counter_o), 32'(c));
            check(32'(pwm_seen), 32'(n));
            doze_mode_i  <= 1'b0;
            debug_mode_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            fire_trig(4'h5);
            repeat (8) @(posedge clk_i);
            check(32'(pwm_seen), 32'(n));
            fire_trig(4'h2);
            repeat (8) @(posedge clk_i);
            check(32'(pwm_seen), 32'(n + 1));
        end
        // reload off: trigger leaves the counter alone
        wr(8'h00, 32'h0000_0000);
        wr(8'h0C, 32'h0200_0000);
        wr(8'h00, 32'h0000_0001);
        n = pwm_seen;
        fire_trig(4'h2);
        repeat (8) @(posedge clk_i);
        check(32'(pwm_seen), 32'(n));
        final_report();
    end
endmodule : timer_trigger_start_reload_stop_test
